// ==== hdl/ccs_pkg.sv ====
// Package for the clock switch and Sleep-exit sequencer.
// Assumes a single 200 MHz system clock; oscillator edges arrive as synchronous inputs.
package ccs_pkg;
   // ==========================================
   // Register map
   localparam logic [3:0] CCS_ADDR_CTRL = 4'h0;
   localparam logic [3:0] CCS_ADDR_STATUS = 4'h1;
   localparam logic [3:0] CCS_ADDR_CPUST = 4'h2;
   // ==========================================
   // Control field positions
   localparam int CCS_CTRL_SEL_LSB = 0;
   localparam int CCS_CTRL_SEC_EN = 2;
   localparam int CCS_CTRL_TWO_SPEED = 3;
   localparam int CCS_CTRL_FREQ_LSB = 4;
   localparam int CCS_CTRL_SLEEP = 7;
   localparam logic [7:0] CCS_CTRL_RESET = 8'h00;
   // ==========================================
   // Clock select encodings
   localparam logic [1:0] CCS_SEL_PRIMARY = 2'h0;
   localparam logic [1:0] CCS_SEL_SECONDARY = 2'h1;
   localparam logic [1:0] CCS_SEL_INTERNAL = 2'h2;
   // Primary oscillator configurations
   localparam logic [2:0] CCS_PRI_LP = 3'h0;
   localparam logic [2:0] CCS_PRI_XT = 3'h1;
   localparam logic [2:0] CCS_PRI_HS = 3'h2;
   localparam logic [2:0] CCS_PRI_EC = 3'h3;
   localparam logic [2:0] CCS_PRI_RC = 3'h4;
   // ==========================================
   // Timing
   localparam int CCS_SWITCH_EDGES = 8;
   localparam int CCS_OST_EDGES = 1024;
   localparam int CCS_STABLE_MS = 4;
   localparam int CCS_CLK_MHZ = 200;
   localparam int CCS_STABLE_CYCLES = CCS_STABLE_MS * 1000 * CCS_CLK_MHZ;
   localparam logic [15:0] CCS_CPUST_RESET = 16'h0400;
   // Source currently clocking the core
   typedef enum logic [1:0] {
      CCS_SRC_PRI = 2'h0,
      CCS_SRC_SEC = 2'h1,
      CCS_SRC_INT = 2'h2
   } ccs_src_e;
   // Oscillator edge strobes travel together
   typedef struct packed {
      logic primary;
      logic secondary;
      logic internal;
   } ccs_edges_s;
endpackage

// ==== hdl/ccs_clock_switch.sv ====
// Clock source switching and Sleep-exit sequencing, one clock domain.
// Oscillator edges arrive as one-cycle strobes synchronous to clock_i.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module ccs_clock_switch #(
   parameter int STABLE_CYCLES = ccs_pkg::CCS_STABLE_CYCLES
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Register port
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   // Configuration and events
   input wire logic [2:0] primary_cfg_i,
   input wire ccs_pkg::ccs_edges_s osc_edge_i,
   input wire logic wake_irq_i,
   // Core clock state
   output ccs_pkg::ccs_src_e clock_source_o,
   output logic core_run_o,
   output logic sleeping_o
);
   import ccs_pkg::*;

   typedef enum logic [4:0] {
      ST_RESET = 5'b00001,
      ST_RUN = 5'b00010,
      ST_SWITCH = 5'b00100,
      ST_SLEEP = 5'b01000,
      ST_WAKE = 5'b10000
   } ccs_state_e;

   function automatic logic is_crystal(input logic [2:0] cfg);
      is_crystal = (cfg == CCS_PRI_LP) || (cfg == CCS_PRI_XT) || (cfg == CCS_PRI_HS);
   endfunction

   function automatic logic src_edge(input ccs_src_e s, input ccs_edges_s e);
      case (s)
         CCS_SRC_SEC: src_edge = e.secondary;
         CCS_SRC_INT: src_edge = e.internal;
         default: src_edge = e.primary;
      endcase
   endfunction

   function automatic ccs_src_e sel_src(input logic [1:0] sel);
      case (sel)
         CCS_SEL_SECONDARY: sel_src = CCS_SRC_SEC;
         CCS_SEL_INTERNAL: sel_src = CCS_SRC_INT;
         default: sel_src = CCS_SRC_PRI;
      endcase
   endfunction

   // Source taken on leaving Sleep; two-speed bridges an unfinished start-up on the internal clock
   function automatic ccs_src_e wake_src(input logic [1:0] sel, input logic [2:0] cfg, input logic ost_ok);
      if (sel != CCS_SEL_PRIMARY) begin
         wake_src = sel_src(sel);
      end else if (ost_ok || !is_crystal(cfg)) begin
         wake_src = CCS_SRC_PRI;
      end else begin
         wake_src = CCS_SRC_INT;
      end
   endfunction

   // Status word layout; bit positions are shared with software
   function automatic logic [15:0] pack_status(input logic sleep, input logic run, input ccs_src_e src,
                                               input logic sec_run, input logic int_ok, input logic ost_ok);
      pack_status = {9'h000, sleep, run, src, sec_run, int_ok, ost_ok};
   endfunction

   ccs_state_e state;
   logic [7:0] ctrl;
   logic [15:0] cpu_start;
   logic [15:0] cpu_cnt;
   logic [10:0] ost_cnt;
   logic ost_run;
   logic [3:0] sw_cnt;
   logic [31:0] stab_cnt;
   logic osc_startup_status;
   logic internal_osc_stable;
   logic secondary_clock_running;
   ccs_src_e target;
   logic [1:0] system_clock_select;
   logic two_speed;
   logic ost_done;
   logic cpu_done;
   logic wr_ctrl;
   logic wr_cpust;
   logic wake_evt;
   logic ost_arm;
   logic ost_need;
   logic sw_step;
   logic sw_last;
   logic [15:0] status_word;

   assign system_clock_select = ctrl[CCS_CTRL_SEL_LSB +: 2];
   assign two_speed = ctrl[CCS_CTRL_TWO_SPEED];
   assign ost_done = !ost_run;
   assign cpu_done = (cpu_cnt == 16'h0000);
   assign wr_ctrl = wr_i && (addr_i == CCS_ADDR_CTRL);
   assign wr_cpust = wr_i && (addr_i == CCS_ADDR_CPUST);
   assign wake_evt = (state == ST_SLEEP) && wake_irq_i;
   // Start-up timer restarts on reset, on every wake-up and on a return to the primary select
   assign ost_arm = (state == ST_RESET) || wake_evt ||
                    (wr_ctrl && wdata_i[1:0] == CCS_SEL_PRIMARY && system_clock_select != CCS_SEL_PRIMARY);
   // Only a crystal primary needs it; a wake-up onto another select leaves it idle
   assign ost_need = is_crystal(primary_cfg_i) &&
                     ((state != ST_SLEEP) || (system_clock_select == CCS_SEL_PRIMARY));
   // A crystal primary must finish its start-up before the 8 settling edges count
   assign sw_step = !(target == CCS_SRC_PRI && ost_run) && src_edge(target, osc_edge_i);
   assign sw_last = (sw_cnt == 4'(CCS_SWITCH_EDGES - 1));
   assign status_word = pack_status(sleeping_o, core_run_o, clock_source_o, secondary_clock_running,
                                    internal_osc_stable, osc_startup_status);

   // ==========================================
   // Register writes
   // Select field only changes by software, never by Sleep entry or exit
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl <= CCS_CTRL_RESET;
         cpu_start <= CCS_CPUST_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl <= wdata_i[7:0];
         end else if (wake_evt) begin
            // A software write on the same edge wins over this clear
            ctrl[CCS_CTRL_SLEEP] <= 1'b0;
         end
         if (wr_cpust) begin
            cpu_start <= wdata_i;
         end
      end
   end

   // ==========================================
   // Oscillator start-up timer, counts primary edges
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ost_run <= 1'b0;
         ost_cnt <= 11'h000;
      end else if (ost_arm) begin
         ost_run <= ost_need;
         ost_cnt <= 11'h000;
      end else if (ost_run && osc_edge_i.primary) begin
         if (ost_cnt == 11'(CCS_OST_EDGES - 1)) begin
            ost_run <= 1'b0;
         end
         ost_cnt <= ost_cnt + 11'h001;
      end
   end

   // ==========================================
   // CPU start-up timer, reloaded on every wake-up
   // Counts system clocks; a load of zero lets the core go on the next cycle
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cpu_cnt <= 16'h0000;
      end else if (wake_evt) begin
         cpu_cnt <= cpu_start;
      end else if (!cpu_done) begin
         cpu_cnt <= cpu_cnt - 16'h0001;
      end
   end

   // ==========================================
   // Sequencer
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= ST_RESET;
         target <= CCS_SRC_PRI;
         clock_source_o <= CCS_SRC_PRI;
         core_run_o <= 1'b0;
         sleeping_o <= 1'b0;
         sw_cnt <= 4'h0;
         osc_startup_status <= 1'b0;
         secondary_clock_running <= 1'b0;
      end else begin
         case (state)
            ST_RESET: begin
               // Reset performs no switch sequence
               // With two-speed the core runs from the internal clock until the start-up timer ends
               if (is_crystal(primary_cfg_i) && two_speed) begin
                  clock_source_o <= CCS_SRC_INT;
                  core_run_o <= 1'b1;
               end
               state <= ST_WAKE;
            end
            ST_RUN: begin
               core_run_o <= 1'b1;
               if (ctrl[CCS_CTRL_SLEEP]) begin
                  core_run_o <= 1'b0;
                  sleeping_o <= 1'b1;
                  state <= ST_SLEEP;
               end else if (sel_src(system_clock_select) != clock_source_o) begin
                  target <= sel_src(system_clock_select);
                  sw_cnt <= 4'h0;
                  state <= ST_SWITCH;
               end
            end
            ST_SWITCH: begin
               // Core keeps running on the old source while the new one settles
               if (ctrl[CCS_CTRL_SLEEP]) begin
                  core_run_o <= 1'b0;
                  sleeping_o <= 1'b1;
                  state <= ST_SLEEP;
               end else if (sel_src(system_clock_select) != target) begin
                  state <= ST_RUN;
               end else if (sw_step) begin
                  sw_cnt <= sw_cnt + 4'h1;
                  if (sw_last) begin
                     clock_source_o <= target;
                     osc_startup_status <= (target == CCS_SRC_PRI);
                     secondary_clock_running <= (target == CCS_SRC_SEC);
                     state <= ST_RUN;
                  end
               end
            end
            ST_SLEEP: begin
               if (wake_irq_i) begin
                  state <= ST_WAKE;
               end
            end
            ST_WAKE: begin
               // Wake-up: the CPU timer and, for a crystal on the primary select, the start-up timer already started together
               if (system_clock_select == CCS_SEL_PRIMARY) begin
                  if (cpu_done && (ost_done || two_speed)) begin
                     core_run_o <= 1'b1;
                     sleeping_o <= 1'b0;
                     clock_source_o <= wake_src(system_clock_select, primary_cfg_i, ost_done);
                     osc_startup_status <= ost_done;
                     secondary_clock_running <= 1'b0;
                     state <= ST_RUN;
                  end
               end else if (cpu_done) begin
                  core_run_o <= 1'b1;
                  sleeping_o <= 1'b0;
                  clock_source_o <= wake_src(system_clock_select, primary_cfg_i, ost_done);
                  osc_startup_status <= 1'b0;
                  secondary_clock_running <= (system_clock_select == CCS_SEL_SECONDARY);
                  state <= ST_RUN;
               end
            end
            default: begin
               // An illegal state code restarts the start-up sequence instead of hanging the core
               core_run_o <= 1'b0;
               sleeping_o <= 1'b0;
               state <= ST_RESET;
            end
         endcase
      end
   end

   // ==========================================
   // Internal oscillator stable flag
   // Counter parks at its end value and restarts whenever the core leaves the internal clock
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stab_cnt <= 32'h00000000;
         internal_osc_stable <= 1'b0;
      end else if (clock_source_o != CCS_SRC_INT) begin
         stab_cnt <= 32'h00000000;
         internal_osc_stable <= 1'b0;
      end else if (stab_cnt == 32'(STABLE_CYCLES - 1)) begin
         internal_osc_stable <= 1'b1;
      end else begin
         stab_cnt <= stab_cnt + 32'h00000001;
      end
   end

   // ==========================================
   // Read port, data one cycle after the strobe
   // Idle cycles and unmapped addresses read zero so no stale word lingers
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         case (addr_i)
            CCS_ADDR_CTRL: rdata_o <= {8'h00, ctrl};
            CCS_ADDR_STATUS: rdata_o <= status_word;
            CCS_ADDR_CPUST: rdata_o <= cpu_start;
            default: rdata_o <= 16'h0000;
         endcase
      end else begin
         rdata_o <= 16'h0000;
      end
   end
endmodule // ccs_clock_switch

// ==== dv/ccs_assertions.sv ====
// Port checker for the clock switch and Sleep-exit sequencer.
// Assumes it is bound onto ccs_clock_switch and sees only its ports.
`timescale 1ns/1ps
module ccs_assertions
   import ccs_pkg::*;
#(
   parameter int STABLE_CYCLES = 20
) (
   // Watched ports
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic [2:0] primary_cfg_i,
   input wire ccs_pkg::ccs_edges_s osc_edge_i,
   input wire logic wake_irq_i,
   input wire ccs_pkg::ccs_src_e clock_source_o,
   input wire logic core_run_o,
   input wire logic sleeping_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   // ==========================================
   // Switching; reset and wake paths are exempt since they move without a strobe
   a_int_strobe: assert property ($changed(clock_source_o) && clock_source_o == CCS_SRC_INT
      && $past(resetn_i) && !$past(sleeping_o) |-> $past(osc_edge_i.internal)) else $error("bad internal switch");
   a_sec_strobe: assert property ($changed(clock_source_o) && clock_source_o == CCS_SRC_SEC
      && $past(resetn_i) && !$past(sleeping_o) |-> $past(osc_edge_i.secondary)) else $error("bad secondary switch");
   a_pri_strobe: assert property ($changed(clock_source_o) && clock_source_o == CCS_SRC_PRI
      && $past(resetn_i) && !$past(sleeping_o) |-> $past(osc_edge_i.primary)) else $error("bad primary switch");
   // ==========================================
   // Start-up, Sleep and read port
   a_reset_halt: assert property (!$past(resetn_i) && primary_cfg_i <= CCS_PRI_HS
      |-> !core_run_o [*8]) else $error("core ran before start-up timer");
   a_sleep_waits: assert property ($rose(sleeping_o) ##0 !wake_irq_i [*4] |-> sleeping_o)
      else $error("left Sleep without interrupt");
   a_exit_runs: assert property ($fell(sleeping_o) |-> core_run_o) else $error("exit without run");
   a_sleep_stops: assert property ($rose(sleeping_o) |-> !core_run_o) else $error("core runs in Sleep");
   a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000) else $error("read data outside slot");
endmodule // ccs_assertions

bind ccs_clock_switch ccs_assertions #(.STABLE_CYCLES(STABLE_CYCLES)) ccs_assertions_i (.clock_i, .resetn_i,
   .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .primary_cfg_i, .osc_edge_i, .wake_irq_i, .clock_source_o,
   .core_run_o, .sleeping_o);

// ==== dv/ccs_osc_model.sv ====
// Oscillator model: one-cycle edge strobes of the three clock sources.
// Assumes every oscillator is slower than the system clock.
`timescale 1ns/1ps
module ccs_osc_model
   import ccs_pkg::*;
#(
   parameter int PRI_DIV = 2,
   parameter int SEC_DIV = 7,
   parameter int INT_DIV = 3
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic resetn_i,
   // Edge strobes
   output ccs_pkg::ccs_edges_s edge_o
);
   int cnt;
   // Oscillators keep running through Sleep, as a crystal does
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
   assign edge_o.primary = (cnt % PRI_DIV) == 0;
   assign edge_o.secondary = (cnt % SEC_DIV) == 0;
   assign edge_o.internal = (cnt % INT_DIV) == 0;
endmodule // ccs_osc_model

// ==== dv/tb_top.sv ====
// Self-checking bench for the clock switch and Sleep-exit sequencer.
// Assumes the oscillator model feeds the edge strobes.
`timescale 1ns/1ps
module tb_top;
   import ccs_pkg::*;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic irq = 1'b0;
   logic [2:0] cfg = CCS_PRI_XT;
   logic [2:0] pri [5] = '{CCS_PRI_LP, CCS_PRI_XT, CCS_PRI_HS, CCS_PRI_EC, CCS_PRI_RC};
   logic [15:0] rdata;
   logic [15:0] v;
   logic core_run;
   logic sleeping;
   ccs_edges_s edges;
   ccs_src_e src;
   int n_fail = 0;
   int comparisons = 0;
   always #2.5 clock_i = ~clock_i;
   ccs_osc_model ccs_osc_model_i (.clock_i, .resetn_i, .edge_o(edges));
   ccs_clock_switch #(.STABLE_CYCLES(20)) ccs_clock_switch_i (.clock_i, .resetn_i, .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .primary_cfg_i(cfg), .osc_edge_i(edges),
      .wake_irq_i(irq), .clock_source_o(src), .core_run_o(core_run), .sleeping_o(sleeping));
   // ==========================================
   // Tasks
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s seen %h want %h", $time, what, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   function automatic logic [3:0] st();
      return {src, sleeping, core_run};
   endfunction
   // Bounded wait for {source, sleeping, run}; a miss ends the run
   task automatic wfor(input logic [3:0] e, input int lim);
      for (int i = 0; i < lim && st() !== e; i++) begin
         @(posedge clock_i);
         #1;
      end
      chk({12'h000, st()}, {12'h000, e}, "state");
      if (st() !== e) begin
         summarize();
      end
   endtask
   task automatic idle_chk(input int n, input logic [15:0] exp, input string what);
      repeat (n) @(posedge clock_i);
      #1;
      chk({13'h0000, src, sleeping}, exp, what);
   endtask
   task automatic pulse_irq();
      @(posedge clock_i);
      irq <= 1'b1;
      @(posedge clock_i);
      irq <= 1'b0;
   endtask
   // ==========================================
   // Sequence
   initial begin
      repeat (5) @(posedge clock_i);
      resetn_i <= 1'b1;
      repeat (100) @(posedge clock_i);
      #1;
      chk({15'h0000, core_run}, 16'h0000, "crystal halt");
      rd_reg(CCS_ADDR_CTRL, v);
      chk(v, {8'h00, CCS_CTRL_RESET}, "ctrl reset");
      rd_reg(CCS_ADDR_CPUST, v);
      chk(v, CCS_CPUST_RESET, "cpu count reset");
      rd_reg(4'hF, v);
      chk(v, 16'h0000, "unmapped");
      wfor({CCS_SRC_PRI, 2'b01}, 3000);
      $display("test reset done");
      wr_reg(CCS_ADDR_CTRL, 16'h0002);
      idle_chk(12, 16'h0000, "early internal");
      wfor({CCS_SRC_INT, 2'b01}, 100);
      rd_reg(CCS_ADDR_STATUS, v);
      chk(v, 16'h0030, "not yet stable");
      repeat (25) @(posedge clock_i);
      rd_reg(CCS_ADDR_STATUS, v);
      chk(v, 16'h0032, "internal flags");
      $display("test internal done");
      foreach (pri[k]) begin
         @(posedge clock_i);
         cfg <= pri[k];
         wr_reg(CCS_ADDR_CTRL, 16'h0005);
         wfor({CCS_SRC_SEC, 2'b01}, 200);
         rd_reg(CCS_ADDR_STATUS, v);
         chk(v & 16'hFFFD, 16'h002C, "secondary flags");
         wr_reg(CCS_ADDR_CTRL, 16'h0004);
         if (pri[k] <= CCS_PRI_HS) begin
            idle_chk(1000, 16'h0002, "still secondary");
         end
         wfor({CCS_SRC_PRI, 2'b01}, (pri[k] <= CCS_PRI_HS) ? 2000 : 60);
         rd_reg(CCS_ADDR_STATUS, v);
         chk(v & 16'hFFFD, 16'h0021, "primary flags");
      end
      $display("test primary done");
      wr_reg(CCS_ADDR_CPUST, 16'h0010);
      wr_reg(CCS_ADDR_CTRL, 16'h0002);
      wfor({CCS_SRC_INT, 2'b01}, 100);
      wr_reg(CCS_ADDR_CTRL, 16'h0082);
      wfor({CCS_SRC_INT, 2'b10}, 10);
      idle_chk(20, 16'h0005, "no wake");
      pulse_irq();
      idle_chk(8, 16'h0005, "cpu timer");
      wfor({CCS_SRC_INT, 2'b01}, 40);
      rd_reg(CCS_ADDR_CTRL, v);
      chk(v, 16'h0002, "select kept");
      $display("test sleep internal done");
      @(posedge clock_i);
      cfg <= CCS_PRI_XT;
      wr_reg(CCS_ADDR_CTRL, 16'h0005);
      wfor({CCS_SRC_SEC, 2'b01}, 200);
      wr_reg(CCS_ADDR_CTRL, 16'h0084);
      wfor({CCS_SRC_SEC, 2'b10}, 10);
      pulse_irq();
      idle_chk(100, 16'h0003, "start-up timer");
      wfor({CCS_SRC_PRI, 2'b01}, 2200);
      $display("test sleep crystal done");
      // Two-speed wake: run on the internal clock until the start-up timer ends
      wr_reg(CCS_ADDR_CTRL, 16'h0088);
      wfor({CCS_SRC_PRI, 2'b10}, 10);
      pulse_irq();
      wfor({CCS_SRC_INT, 2'b01}, 40);
      rd_reg(CCS_ADDR_STATUS, v);
      chk(v & 16'hFFFD, 16'h0030, "two-speed wake flags");
      wfor({CCS_SRC_PRI, 2'b01}, 2200);
      rd_reg(CCS_ADDR_STATUS, v);
      chk(v & 16'hFFFD, 16'h0021, "after two-speed");
      $display("test two-speed done");
      // Mid-run reset with an external clock primary needs no start-up wait
      @(posedge clock_i);
      cfg <= CCS_PRI_EC;
      resetn_i <= 1'b0;
      repeat (5) @(posedge clock_i);
      resetn_i <= 1'b1;
      wfor({CCS_SRC_PRI, 2'b01}, 10);
      rd_reg(CCS_ADDR_CTRL, v);
      chk(v, {8'h00, CCS_CTRL_RESET}, "ctrl after reset");
      $display("test reset ec done");
      summarize();
   end
endmodule // tb_top
